// >>> src/self_test_pkg.sv
// Constants for the self-test result flag bank and its serial frame port
// Operation
// (RULE1) First result register at 0x0D; 16-bit frame, 5-bit address.
// (RULE2) Second result register at 0x0E holds four flags in data bits 4..1.
// (RULE3) Bit D7 of first register reports the built-in self-test failure.
// (RULE4) Bit D6 of first register reports thermal monitor check failure.
// (RULE5) Bits D5/D4 report pre-regulator over/under check failures.
// (RULE6) Bits D3/D2 report MCU supply over/under check failures.
// (RULE7) Bits D1/D0 report general regulator over/under check failures.
// (RULE8) Second register bits 4/3 report sensor A over/under failures.
// (RULE9) Second register bits 2/1 report sensor B over/under failures.
// (RULE10) Set flags stay set until host writes 1; new failure sets again.
// (RULE11) Unused bits read 0, ignore writes; all flags clear on reset.
package self_test_pkg;

  // Frame layout
  localparam int        FRAME_W      = 16;
  localparam int        ADDR_HI      = 15;
  localparam int        ADDR_LO      = 11;
  localparam int        TYPE_POS     = 10;
  localparam int        DATA_HI      = 8;
  localparam int        DATA_LO      = 1;
  localparam int        PARITY_POS   = 0;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;

  // Register map
  localparam logic [4:0] ADDR_RESULT_A = 5'h0D;
  localparam logic [4:0] ADDR_RESULT_B = 5'h0E;

  // Field positions, first register
  localparam int POS_BUILTIN      = 7;
  localparam int POS_THERMAL      = 6;
  localparam int POS_PREREG_OVER  = 5;
  localparam int POS_PREREG_UNDER = 4;
  localparam int POS_MCU_OVER     = 3;
  localparam int POS_MCU_UNDER    = 2;
  localparam int POS_GEN_OVER     = 1;
  localparam int POS_GEN_UNDER    = 0;

  // Field positions, second register
  localparam int POS_SENS_A_OVER  = 4;
  localparam int POS_SENS_A_UNDER = 3;
  localparam int POS_SENS_B_OVER  = 2;
  localparam int POS_SENS_B_UNDER = 1;

  // Implemented bits and reset values
  localparam logic [7:0] MASK_RESULT_A  = 8'hFF;
  localparam logic [7:0] MASK_RESULT_B  = 8'h1E;
  localparam logic [7:0] RESET_RESULT_A = 8'h00;
  localparam logic [7:0] RESET_RESULT_B = 8'h00;

  // Frame type bit value for a write
  localparam logic       TYPE_WRITE     = 1'b1;

endpackage

// >>> src/self_test_result_flags.sv
// Sticky self-test result flags behind the serial register frame port
`timescale 1ns/1ps
module self_test_result_flags
  import self_test_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Serial register pins
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe_n,
  // Self-check failure events, first register
  input  wire logic builtin_test_failed,
  input  wire logic thermal_check_failed,
  input  wire logic prereg_over_check_failed,
  input  wire logic prereg_under_check_failed,
  input  wire logic mcu_rail_over_check_failed,
  input  wire logic mcu_rail_under_check_failed,
  input  wire logic general_rail_over_check_failed,
  input  wire logic general_rail_under_check_failed,
  // Self-check failure events, second register
  input  wire logic sensor_a_over_check_failed,
  input  wire logic sensor_a_under_check_failed,
  input  wire logic sensor_b_over_check_failed,
  input  wire logic sensor_b_under_check_failed,
  // Flag state
  output logic      any_check_failed
);

  logic               frame_valid;
  logic [FRAME_W-1:0] frame_word;
  logic [FRAME_W-1:0] tx_word_q;
  logic [7:0]         flags_a_q;
  logic [7:0]         flags_b_q;
  logic [7:0]         flags_a_d;
  logic [7:0]         flags_b_d;
  logic [7:0]         set_a;
  logic [7:0]         set_b;
  logic [7:0]         clr_a;
  logic [7:0]         clr_b;
  logic [4:0]         addr;
  logic [7:0]         wdata;
  logic               frame_ok;
  logic               wr_a;
  logic               wr_b;

  // Odd parity over a whole frame
  function automatic logic parity_ok(input logic [FRAME_W-1:0] w);
    parity_ok = ^w;
  endfunction

  // Read value of an addressed register
  function automatic logic [7:0] read_reg(input logic [4:0] a,
                                          input logic [7:0] ra,
                                          input logic [7:0] rb);
    if (a == ADDR_RESULT_A) begin
      read_reg = ra & MASK_RESULT_A;
    end else if (a == ADDR_RESULT_B) begin
      read_reg = rb & MASK_RESULT_B;
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  serial_frame_port u_port (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .sck         (sck),
    .cs_n        (cs_n),
    .sdi         (sdi),
    .sdo         (sdo),
    .sdo_oe_n    (sdo_oe_n),
    .tx_word     (tx_word_q),
    .frame_valid (frame_valid),
    .frame_word  (frame_word)
  );

  // Frame decode
  assign addr     = frame_word[ADDR_HI:ADDR_LO];
  assign wdata    = frame_word[DATA_HI:DATA_LO];
  assign frame_ok = frame_valid && parity_ok(frame_word);
  assign wr_a = frame_ok && (frame_word[TYPE_POS] == TYPE_WRITE)
                && (addr == ADDR_RESULT_A); // see (RULE1)
  assign wr_b = frame_ok && (frame_word[TYPE_POS] == TYPE_WRITE)
                && (addr == ADDR_RESULT_B); // see (RULE2)

  // Event mapping onto flag positions
  always_comb begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_a[POS_BUILTIN]      = builtin_test_failed;            // see (RULE3)
    set_a[POS_THERMAL]      = thermal_check_failed;           // see (RULE4)
    set_a[POS_PREREG_OVER]  = prereg_over_check_failed;       // see (RULE5)
    set_a[POS_PREREG_UNDER] = prereg_under_check_failed;      // see (RULE5)
    set_a[POS_MCU_OVER]     = mcu_rail_over_check_failed;     // see (RULE6)
    set_a[POS_MCU_UNDER]    = mcu_rail_under_check_failed;    // see (RULE6)
    set_a[POS_GEN_OVER]     = general_rail_over_check_failed; // see (RULE7)
    set_a[POS_GEN_UNDER]    = general_rail_under_check_failed; // see (RULE7)
    set_b[POS_SENS_A_OVER]  = sensor_a_over_check_failed;     // see (RULE8)
    set_b[POS_SENS_A_UNDER] = sensor_a_under_check_failed;    // see (RULE8)
    set_b[POS_SENS_B_OVER]  = sensor_b_over_check_failed;     // see (RULE9)
    set_b[POS_SENS_B_UNDER] = sensor_b_under_check_failed;    // see (RULE9)
  end

  // Write-one-to-clear, set wins over clear
  assign clr_a     = wr_a ? (wdata & MASK_RESULT_A) : 8'h00; // see (RULE10)
  assign clr_b     = wr_b ? (wdata & MASK_RESULT_B) : 8'h00; // see (RULE11)
  assign flags_a_d = ((flags_a_q & ~clr_a) | set_a) & MASK_RESULT_A;
  assign flags_b_d = ((flags_b_q & ~clr_b) | set_b) & MASK_RESULT_B;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_a_q <= RESET_RESULT_A; // see (RULE11)
      flags_b_q <= RESET_RESULT_B; // see (RULE11)
    end else begin
      flags_a_q <= flags_a_d; // see (RULE10)
      flags_b_q <= flags_b_d; // see (RULE10)
    end
  end

  // Reply for next frame: address echo, data before this frame's write
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_word_q <= '0;
    end else if (frame_ok) begin
      tx_word_q <= {addr, 2'b00, read_reg(addr, flags_a_q, flags_b_q),
                    ~^{addr, read_reg(addr, flags_a_q, flags_b_q)}};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      any_check_failed <= 1'b0;
    end else begin
      any_check_failed <= |{flags_a_d, flags_b_d};
    end
  end

  // Checks
  sequence s_write_a_bit7;
    wr_a && wdata[POS_BUILTIN] && !builtin_test_failed;
  endsequence

  property p_builtin_set;
    @(posedge clk_sys) disable iff (srst)
      builtin_test_failed |=> flags_a_q[POS_BUILTIN];
  endproperty
  a_builtin_set: assert property (p_builtin_set) // see (RULE3)
    else $error("builtin flag not set after failure");

  property p_thermal_set;
    @(posedge clk_sys) disable iff (srst)
      thermal_check_failed |=> flags_a_q[POS_THERMAL] && any_check_failed;
  endproperty
  a_thermal_set: assert property (p_thermal_set) // see (RULE4)
    else $error("thermal flag not set after failure");

  property p_prereg_set;
    @(posedge clk_sys) disable iff (srst)
      prereg_under_check_failed |=> flags_a_q[POS_PREREG_UNDER];
  endproperty
  a_prereg_set: assert property (p_prereg_set) // see (RULE5)
    else $error("pre-regulator under flag not set");

  property p_prereg_over_set;
    @(posedge clk_sys) disable iff (srst)
      prereg_over_check_failed |=> flags_a_q[POS_PREREG_OVER];
  endproperty
  a_prereg_over_set: assert property (p_prereg_over_set) // see (RULE5)
    else $error("pre-regulator over flag not set");

  property p_mcu_set;
    @(posedge clk_sys) disable iff (srst)
      mcu_rail_over_check_failed |=> flags_a_q[POS_MCU_OVER];
  endproperty
  a_mcu_set: assert property (p_mcu_set) // see (RULE6)
    else $error("mcu rail flag not set");

  property p_general_set;
    @(posedge clk_sys) disable iff (srst)
      general_rail_under_check_failed |=> flags_a_q[POS_GEN_UNDER];
  endproperty
  a_general_set: assert property (p_general_set) // see (RULE7)
    else $error("general rail flag not set");

  property p_sensor_a_set;
    @(posedge clk_sys) disable iff (srst)
      sensor_a_over_check_failed |=> flags_b_q[POS_SENS_A_OVER];
  endproperty
  a_sensor_a_set: assert property (p_sensor_a_set) // see (RULE8)
    else $error("sensor A flag not set");

  property p_sensor_b_set;
    @(posedge clk_sys) disable iff (srst)
      sensor_b_under_check_failed |=> flags_b_q[POS_SENS_B_UNDER];
  endproperty
  a_sensor_b_set: assert property (p_sensor_b_set) // see (RULE9)
    else $error("sensor B flag not set");

  property p_clear_a;
    @(posedge clk_sys) disable iff (srst)
      s_write_a_bit7 |=> !flags_a_q[POS_BUILTIN];
  endproperty
  a_clear_a: assert property (p_clear_a) // see (RULE10)
    else $error("write one did not clear flag");

  // New failure in the clearing cycle keeps the flag
  property p_set_wins;
    @(posedge clk_sys) disable iff (srst)
      wr_a && wdata[POS_THERMAL] && thermal_check_failed
        |=> flags_a_q[POS_THERMAL];
  endproperty
  a_set_wins: assert property (p_set_wins) // see (RULE10)
    else $error("clear beat a new failure");

  property p_hold;
    @(posedge clk_sys) disable iff (srst)
      !wr_a |=> (flags_a_q & $past(flags_a_q)) == $past(flags_a_q);
  endproperty
  a_hold: assert property (p_hold) // see (RULE10)
    else $error("flag dropped without a write");

  property p_addr_b_only;
    @(posedge clk_sys) disable iff (srst)
      wr_b |=> (flags_a_q & $past(flags_a_q)) == $past(flags_a_q);
  endproperty
  a_addr_b_only: assert property (p_addr_b_only) // see (RULE2)
    else $error("second register write touched first");

  property p_unused_zero;
    @(posedge clk_sys) disable iff (srst)
      1'b1 |-> (flags_b_q & ~MASK_RESULT_B) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // see (RULE11)
    else $error("unused bit set");

  property p_reset_clear;
    @(posedge clk_sys) srst |=> flags_a_q == 8'h00 && flags_b_q == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // see (RULE11)
    else $error("flags not clear after reset");

endmodule // self_test_result_flags

// >>> src/serial_frame_port.sv
// Serial frame receiver and transmitter, clock-phase 0, chip select low
`timescale 1ns/1ps
module serial_frame_port
  import self_test_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // Serial pins
  input  wire logic               sck,
  input  wire logic               cs_n,
  input  wire logic               sdi,
  output logic                    sdo,
  output logic                    sdo_oe_n,
  // Frame side
  input  wire logic [FRAME_W-1:0] tx_word,
  output logic                    frame_valid,
  output logic [FRAME_W-1:0]      frame_word
);

  logic [2:0]         sck_sq;
  logic [2:0]         cs_sq;
  logic [1:0]         sdi_sq;
  logic [FRAME_W-1:0] rx_q;
  logic [FRAME_W-1:0] tx_q;
  logic [4:0]         cnt_q;
  logic               sck_rise;
  logic               sck_fall;
  logic               cs_fall;
  logic               cs_rise;

  // Two-stage synchronisers; edges use stages two and three only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sck_sq <= 3'h0;
      cs_sq  <= 3'h7;
      sdi_sq <= 2'h0;
    end else begin
      sck_sq <= {sck_sq[1:0], sck};
      cs_sq  <= {cs_sq[1:0], cs_n};
      sdi_sq <= {sdi_sq[0], sdi};
    end
  end

  assign sck_rise = sck_sq[1] & ~sck_sq[2] & ~cs_sq[1];
  assign sck_fall = ~sck_sq[1] & sck_sq[2] & ~cs_sq[1];
  assign cs_fall  = ~cs_sq[1] & cs_sq[2];
  assign cs_rise  = cs_sq[1] & ~cs_sq[2];

  // Receive shift and bit count
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_q  <= '0;
      cnt_q <= 5'h00;
    end else if (cs_fall) begin
      cnt_q <= 5'h00;
    end else if (sck_rise) begin
      rx_q <= {rx_q[FRAME_W-2:0], sdi_sq[1]};
      if (cnt_q != 5'h1F) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // Transmit shift, first bit ready before first rising edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_q <= '0;
      sdo  <= 1'b0;
    end else if (cs_fall) begin
      tx_q <= tx_word;
      sdo  <= tx_word[FRAME_W-1];
    end else if (sck_fall) begin
      tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
      sdo  <= tx_q[FRAME_W-2];
    end
  end

  // Output driven only while selected
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= cs_sq[1];
    end
  end

  // Only complete 16-bit frames are delivered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frame_valid <= 1'b0;
      frame_word  <= '0;
    end else begin
      frame_valid <= cs_rise && (cnt_q == BIT_COUNT_FULL);
      if (cs_rise && (cnt_q == BIT_COUNT_FULL)) begin
        frame_word <= rx_q;
      end
    end
  end

endmodule // serial_frame_port

// >>> verif/host_spi_model.sv
// Host controller model that drives serial register frames
`timescale 1ns/1ps
module host_spi_model (
  // Clock
  input  wire logic clk_sys,
  // Serial pins
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One frame MSB first; fewer than 16 bits gives a runt frame
  task automatic xfer(input logic [15:0] w, input int nbits,
                      output logic [15:0] rsp);
    rsp = 16'h0000;
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(4);
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi = w[i];
      wait_clk(4);
      rsp = {rsp[14:0], sdo_oe_n ? 1'bx : sdo};
      sck = 1'b1;
      wait_clk(4);
      sck = 1'b0;
    end
    wait_clk(4);
    cs_n = 1'b1;
    // Released data line must not keep its last level
    sdi  = ~sdi;
    wait_clk(6);
  endtask
endmodule // host_spi_model

// >>> verif/tb_top.sv
// Self-checking bench for the self-test result flag bank
`timescale 1ns/1ps
module tb_top;
  import self_test_pkg::*;
  logic        clk_sys;
  logic        srst;
  logic [11:0] ev;
  logic [15:0] rsp;
  logic [7:0]  d;
  wire         sck;
  wire         cs_n;
  wire         sdi;
  wire         sdo;
  wire         sdo_oe_n;
  wire         any_fail;
  int          err_count;
  int          total_checks;

  self_test_result_flags i_dut (
    .clk_sys                         (clk_sys),
    .srst                            (srst),
    .sck                             (sck),
    .cs_n                            (cs_n),
    .sdi                             (sdi),
    .sdo                             (sdo),
    .sdo_oe_n                        (sdo_oe_n),
    .builtin_test_failed             (ev[11]),
    .thermal_check_failed            (ev[10]),
    .prereg_over_check_failed        (ev[9]),
    .prereg_under_check_failed       (ev[8]),
    .mcu_rail_over_check_failed      (ev[7]),
    .mcu_rail_under_check_failed     (ev[6]),
    .general_rail_over_check_failed  (ev[5]),
    .general_rail_under_check_failed (ev[4]),
    .sensor_a_over_check_failed      (ev[3]),
    .sensor_a_under_check_failed     (ev[2]),
    .sensor_b_over_check_failed      (ev[1]),
    .sensor_b_under_check_failed     (ev[0]),
    .any_check_failed                (any_fail)
  );

  host_spi_model i_host (
    .clk_sys  (clk_sys),
    .sck      (sck),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo      (sdo),
    .sdo_oe_n (sdo_oe_n)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Odd parity over the whole frame
  function automatic logic [15:0] mk(input logic [4:0] a, input logic wr,
                                     input logic [7:0] dat);
    mk = {a, wr, 1'b0, dat, 1'b0};
    mk[0] = ~^mk[15:1];
  endfunction

  task automatic frame(input logic [4:0] a, input logic wr,
                       input logic [7:0] dat);
    i_host.xfer(mk(a, wr, dat), 16, rsp);
  endtask

  // Reply of a frame arrives in the next one
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    frame(a, 1'b0, 8'h00);
    frame(a, 1'b0, 8'h00);
    check_bit(^rsp, 1'b1);
    check_byte({3'h0, rsp[15:11]}, {3'h0, a});
    q = rsp[8:1];
  endtask

  task automatic raise(input logic [11:0] v);
    @(negedge clk_sys);
    ev = v;
    @(negedge clk_sys);
    ev = 12'h000;
    @(negedge clk_sys);
  endtask

  task automatic t_reset_values();
    rd(ADDR_RESULT_A, d);
    check_byte(d, 8'h00);
    rd(ADDR_RESULT_B, d);
    check_byte(d, 8'h00);
    check_bit(any_fail, 1'b0);
  endtask

  task automatic t_each_flag();
    logic [11:0] v;
    for (int i = 0; i < 12; i++) begin
      v = 12'h001 << i;
      raise(v);
      check_bit(any_fail, 1'b1);
      rd(ADDR_RESULT_A, d);
      check_byte(d, v[11:4]);
      rd(ADDR_RESULT_B, d);
      check_byte(d, {3'h0, v[3:0], 1'b0});
      frame(i < 4 ? ADDR_RESULT_B : ADDR_RESULT_A, TYPE_WRITE, 8'hFF);
      check_bit(any_fail, 1'b0);
    end
  endtask

  task automatic t_sticky_clear();
    raise(12'hFFF);
    frame(ADDR_RESULT_A, TYPE_WRITE, 8'h00);
    rd(ADDR_RESULT_A, d);
    check_byte(d, 8'hFF);
    frame(ADDR_RESULT_A, TYPE_WRITE, 8'h55);
    rd(ADDR_RESULT_A, d);
    check_byte(d, 8'hAA);
    i_host.xfer(mk(ADDR_RESULT_A, TYPE_WRITE, 8'hFF) ^ 16'h0001, 16, rsp);
    i_host.xfer(mk(ADDR_RESULT_A, TYPE_WRITE, 8'hFF), 12, rsp);
    rd(ADDR_RESULT_A, d);
    check_byte(d, 8'hAA);
    frame(ADDR_RESULT_B, TYPE_WRITE, 8'hE1);
    rd(ADDR_RESULT_B, d);
    check_byte(d, 8'h1E);
    frame(ADDR_RESULT_B, TYPE_WRITE, 8'hFF);
    rd(ADDR_RESULT_B, d);
    check_byte(d, 8'h00);
    raise(12'h00F);
    rd(ADDR_RESULT_B, d);
    check_byte(d, 8'h1E);
    rd(5'h03, d);
    check_byte(d, 8'h00);
    ev = 12'h400;
    frame(ADDR_RESULT_A, TYPE_WRITE, 8'h40);
    ev = 12'h000;
    rd(ADDR_RESULT_A, d);
    check_byte(d, 8'hEA);
  endtask

  task automatic t_mid_reset();
    raise(12'hFFF);
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    check_bit(any_fail, 1'b0);
    rd(ADDR_RESULT_A, d);
    check_byte(d, RESET_RESULT_A);
  endtask

  initial begin
    srst         = 1'b1;
    ev           = 12'h000;
    err_count    = 0;
    total_checks = 0;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    t_reset_values();
    t_each_flag();
    t_sticky_clear();
    t_mid_reset();
    print_verdict();
  end
endmodule // tb_top
